// ### rtl/atw_pkg.sv
// Shared constants and types of the two-wire converter readout block.
// Assumes a 20 MHz system clock and a master-driven serial clock.
`default_nettype none
package atw_pkg;
  // Slave address and master code
  localparam logic [2:0] ADDR_FIXED  = 3'h3;      // Upper address bits 011
  localparam logic [4:0] HS_CODE     = 5'h01;     // Master code 0000_1xxx
  // Byte framing
  localparam logic [3:0] ADDR_BITS   = 4'h7;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] HI_MSB      = 4'hF;      // Upper result byte starts at bit 15
  localparam logic [3:0] LO_MSB      = 4'h7;      // Lower result byte starts at bit 7
  // Converter
  localparam int         RES_W       = 16;
  localparam logic [3:0] RES_MSB     = 4'hF;
  localparam logic [15:0] SAR_FIRST  = 16'h8000;  // First trial code
  localparam int         CLK_HZ      = 20_000_000;
  localparam int         SAR_HZ      = 4_000_000; // Conversion oscillator
  localparam int         SCL_MAX_HZ  = 1_700_000; // Fastest readout clock
  localparam logic [2:0] SAR_DIV_M1  = 3'(CLK_HZ / SAR_HZ - 1);
  // Positions in the crossing synchroniser vector
  localparam int SY_REQ  = 0;
  localparam int SY_WAKE = 1;
  localparam int SY_DOWN = 2;
  localparam int SY_HS   = 3;
  localparam int SY_STOP = 4;
  localparam int SY_EXT  = 5;
  localparam int SY_CMP  = 6;
  localparam int SY_W    = 7;
  // Link and converter states
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ACK, L_HSNACK, L_CONV, L_TX, L_MACK, L_SKIP} atw_lst_t;
  typedef enum logic {C_IDLE, C_RUN} atw_cst_t;
endpackage
`default_nettype wire

// ### rtl/atw_cross_if.sv
// Signals passed between the bus-condition, link and converter logic.
// Toggles cross domains; the result word is quasi-static under the stretch handshake.
`default_nettype none
interface atw_cross_if;
  logic        bit_r;      // Data bit sampled at the rising serial clock
  logic        start_tgl;  // Flips on every start condition
  logic        stop_tgl;   // Flips on every stop condition
  logic        req_tgl;    // Conversion request
  logic        wake_tgl;   // Reference wake request
  logic        down_tgl;   // Reference shutdown request
  logic        hs_tgl;     // High-speed master code seen
  logic        hold;       // Serial clock held low
  logic        ref_on;
  logic        hs;
  logic [15:0] result;
  logic [15:0] code;
  modport cond (output bit_r, start_tgl, stop_tgl);
  modport link (input bit_r, start_tgl, stop_tgl, hold, ref_on, hs, result, code,
                output req_tgl, wake_tgl, down_tgl, hs_tgl);
  modport core (input req_tgl, wake_tgl, down_tgl, hs_tgl, stop_tgl,
                output hold, ref_on, hs, result, code);
endinterface
`default_nettype wire

// ### rtl/atw_cond.sv
// Start and stop detection and data bit capture on the serial lines.
// Assumes the master changes data only while the serial clock is low.
`default_nettype none
module atw_cond
  import atw_pkg::*;
(
  input  wire logic    rst_b,
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  atw_cross_if.cond    cx
);
  // Data bit taken at the rising clock edge
  always_ff @(posedge scl_in or negedge rst_b)
    if (!rst_b)
      cx.bit_r <= 1'b1;
    else
      cx.bit_r <= sda_in;

  // Data falling while clock high is a start
  always_ff @(negedge sda_in or negedge rst_b)
    if (!rst_b)
      cx.start_tgl <= 1'b0;
    else if (scl_in)
      cx.start_tgl <= ~cx.start_tgl;       // [R6] [R4]

  // Data rising while clock high is a stop
  always_ff @(posedge sda_in or negedge rst_b)
    if (!rst_b)
      cx.stop_tgl <= 1'b0;
    else if (scl_in)
      cx.stop_tgl <= ~cx.stop_tgl;         // [R6] [R4]
endmodule // atw_cond
`default_nettype wire

// ### rtl/atw_conv.sv
// System-clock side: successive approximation sequencer, clock stretch,
// reference and timing mode control. Assumes a 20 MHz clk.
`default_nettype none
module atw_conv
  import atw_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst_b,
  input  wire logic    cmp_in,
  input  wire logic    ref_ext,
  atw_cross_if.core    cx
);
  typedef struct packed {
    logic [SY_W-1:0]  s1;
    logic [SY_W-1:0]  s2;
    logic [SY_STOP:0] seen;
    atw_cst_t         st;
    logic [2:0]       div;
    logic [3:0]       bitn;
    logic [15:0]      code;
    logic [15:0]      result;
    logic             hold;
    logic             ref_on;
    logic             hs;
  } atw_conv_t;

  atw_conv_t        s_r;
  atw_conv_t        s_nxt;
  logic [SY_STOP:0] ev;

  // Next state of the sequencer
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.s1   = {cmp_in, ref_ext, cx.stop_tgl, cx.hs_tgl, cx.down_tgl, cx.wake_tgl, cx.req_tgl};
    s_nxt.s2   = s_r.s1;
    ev         = s_r.s2[SY_STOP:0] ^ s_r.seen;
    s_nxt.seen = s_r.s2[SY_STOP:0];
    if (s_r.s2[SY_EXT])
      s_nxt.ref_on = 1'b0;                 // [R12]
    else if (ev[SY_WAKE])
      s_nxt.ref_on = 1'b1;                 // [R23]
    else if (ev[SY_DOWN])
      s_nxt.ref_on = 1'b0;                 // [R22]
    if (ev[SY_HS])
      s_nxt.hs = 1'b1;                     // [R15]
    else if (ev[SY_STOP])
      s_nxt.hs = 1'b0;                     // [R7] [R14]
    case (s_r.st)
      C_IDLE:
      begin
        // Clock released one cycle after the result word settles, so the first data bit never moves with SCL high
        s_nxt.hold = 1'b0;                 // [R18] [R4]
        if (ev[SY_REQ])
        begin
          s_nxt.st   = C_RUN;
          s_nxt.hold = 1'b1;               // [R1] [R21]
          s_nxt.div  = '0;
          s_nxt.bitn = RES_MSB;
          s_nxt.code = SAR_FIRST;
        end
      end
      C_RUN:
      begin
        s_nxt.div = (s_r.div == SAR_DIV_M1) ? '0 : s_r.div + 3'h1;
        if (s_r.div == SAR_DIV_M1)
        begin
          s_nxt.code[s_r.bitn] = s_r.s2[SY_CMP];
          if (s_r.bitn == '0)
          begin
            s_nxt.st     = C_IDLE;
            s_nxt.result = {s_r.code[15:1], s_r.s2[SY_CMP]}; // [R2]
          end
          else
          begin
            s_nxt.bitn                   = s_r.bitn - 4'h1;
            s_nxt.code[s_r.bitn - 4'h1]  = 1'b1;
          end
        end
      end
      default: s_nxt.st = C_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;

  assign cx.hold   = s_r.hold;
  assign cx.ref_on = s_r.ref_on;
  assign cx.hs     = s_r.hs;
  assign cx.result = s_r.result;
  assign cx.code   = s_r.code;

  // Checks on the system clock side
  a_hold_len_exact: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    $rose(s_r.hold) |-> ##80 s_r.hold ##1 !s_r.hold)
    else $error("clock stretch does not cover the conversion plus one settling cycle");
  a_ref_ext_off: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
    s_r.s2[SY_EXT] |=> !s_r.ref_on)
    else $error("reference enabled while external reference selected");
  a_hs_stop_clear: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
    (ev[SY_STOP] && !ev[SY_HS]) |=> !s_r.hs)
    else $error("stop did not return bus to fast timing");
  a_result_before_release: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
    $fell(s_r.hold) |-> $stable(s_r.result))
    else $error("result word changed as the clock was released");
  c_conv_done: cover property (@(posedge clk) disable iff (!rst_b) $fell(s_r.hold));
endmodule // atw_conv
`default_nettype wire

// ### rtl/atw_top.sv
// Two-wire slave readout of a single-channel 16-bit converter: link logic on the
// falling serial clock, converter sequencer on clk. Assumes open-drain pads outside.
// Summary of operation
// [R1] Conversion runs on the 4MHz oscillator while the serial clock is held low.
// [R2] Result is stored internally; master reads it at up to 1.7MHz.
// [R3] One bit per serial clock; each byte takes nine clocks including acknowledge.
// [R4] Data stays stable while clock is high; changes then are control conditions.
// [R5] Both lines rest high when no transfer is in progress.
// [R6] Start is data falling with clock high; stop is data rising; both detected.
// [R7] Stop frees the bus and restores fast timing; repeated start keeps the mode.
// [R8] Receiver acknowledges by holding data low through the ninth clock high phase.
// [R9] Master should watch acknowledges and retry later on failure.
// [R10] Idle device waits for start plus own address, then acquires the input.
// [R11] Address is 011 plus four strapped bits, followed by a direction bit.
// [R12] Internal reference: direction 1 normal, 0 shuts reference down; external ignores it.
// [R13] A matching address is acknowledged by pulling data low for one clock.
// [R14] Power-up uses fast timing; the faster rate needs high-speed timing.
// [R15] Master code 0000_1xxx gets a not-acknowledge, then high-speed timing.
// [R16] After the switch the master sends repeated start and the address.
// [R17] Only reads exist; any matching address starts a conversion and is acknowledged.
// [R18] Clock released at conversion end; upper byte then lower byte, MSB first.
// [R19] Conversions repeat while the master acknowledges; not-acknowledge ends the read.
// [R20] Input is tracked for the two serial clocks before conversion, held otherwise.
// [R21] Converter powers up on a valid address and down after the conversion.
// [R22] Internal reference with direction 0 shuts down on master not-acknowledge.
// [R23] Reference wakes on the ninth falling edge of a valid address byte.
// [R24] Non-matching addresses are neither acknowledged nor driven; wait for next start.
`default_nettype none
module atw_top
  import atw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [3:0]  address_select_pins,
  input  wire logic        reference_adjust_pin,
  input  wire logic        cmp_in,
  output logic [15:0]      sar_code,
  output logic             adc_power,
  output logic             track_en,
  output logic             ref_enable,
  output logic             timing_hs
);
  typedef struct packed {
    logic [3:0]  adr_s1;
    logic [3:0]  adr_s2;
    logic        start_seen;
    logic        stop_seen;
    atw_lst_t    st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic        lower;
    logic        oe;
    logic        track;
    logic        req_tgl;
    logic        wake_tgl;
    logic        down_tgl;
    logic        hs_tgl;
    logic [15:0] data;
  } atw_link_t;

  atw_cross_if cx ();

  atw_link_t  s_r;
  atw_link_t  s_nxt;
  logic       st_ev;
  logic       sp_ev;
  logic [7:0] byte_in;
  logic [3:0] done;
  logic [3:0] bsel;

  // Own address check on the seven address bits
  function automatic logic addr_hit(input logic [6:0] a, input logic [3:0] pins);
    addr_hit = (a == {ADDR_FIXED, pins});
  endfunction

  // Bus condition detector and data sampler
  atw_cond u_cond (
    .rst_b  (rst_b),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .cx     (cx)
  );

  // Converter sequencer on the system clock
  atw_conv u_conv (
    .clk     (clk),
    .rst_b   (rst_b),
    .cmp_in  (cmp_in),
    .ref_ext (reference_adjust_pin),
    .cx      (cx)
  );

  // Next state of the link, evaluated at each falling serial clock edge
  always_comb
  begin
    s_nxt            = s_r;
    s_nxt.adr_s1     = address_select_pins;
    s_nxt.adr_s2     = s_r.adr_s1;
    st_ev            = cx.start_tgl ^ s_r.start_seen;
    sp_ev            = cx.stop_tgl ^ s_r.stop_seen;
    s_nxt.start_seen = cx.start_tgl;
    s_nxt.stop_seen  = cx.stop_tgl;
    byte_in          = {s_r.sh[6:0], cx.bit_r};
    done             = s_r.cnt + 4'h1;
    bsel             = (s_r.lower ? LO_MSB : HI_MSB) - done;
    if (st_ev)
    begin
      // Start or repeated start: timing mode is left alone
      s_nxt.st    = L_ADDR;                // [R6] [R7] [R10]
      s_nxt.cnt   = '0;
      s_nxt.oe    = 1'b0;
      s_nxt.track = 1'b0;
    end
    else if (sp_ev)
    begin
      s_nxt.st    = L_IDLE;                // [R7] [R5]
      s_nxt.oe    = 1'b0;
      s_nxt.track = 1'b0;
    end
    else
    begin
      case (s_r.st)
        L_ADDR:
        begin
          s_nxt.sh  = byte_in;             // [R3]
          s_nxt.cnt = done;
          if (s_r.cnt == ADDR_BITS - 4'h1)
            s_nxt.track = addr_hit(byte_in[6:0], s_r.adr_s2); // [R20]
          if (s_r.cnt == BYTE_BITS - 4'h1)
          begin
            s_nxt.rw = cx.bit_r;
            if (addr_hit(byte_in[7:1], s_r.adr_s2))
            begin
              s_nxt.st = L_ACK;            // [R11] [R17]
              s_nxt.oe = 1'b1;             // [R13] [R8]
            end
            else if (byte_in[7:3] == HS_CODE)
            begin
              s_nxt.st    = L_HSNACK;      // [R15]
              s_nxt.track = 1'b0;
            end
            else
            begin
              s_nxt.st    = L_SKIP;        // [R24]
              s_nxt.track = 1'b0;
            end
          end
        end
        L_ACK:
        begin
          // Ninth falling edge: hold input, convert, wake reference
          s_nxt.oe       = 1'b0;
          s_nxt.track    = 1'b0;           // [R20]
          s_nxt.req_tgl  = ~s_r.req_tgl;   // [R1] [R21]
          s_nxt.wake_tgl = ~s_r.wake_tgl;  // [R23]
          s_nxt.lower    = 1'b0;
          s_nxt.st       = L_CONV;
        end
        L_HSNACK:
        begin
          s_nxt.hs_tgl = ~s_r.hs_tgl;      // [R15]
          s_nxt.st     = L_SKIP;
        end
        L_CONV:
        begin
          // Upper bit already shown; take the word and present the next bit
          s_nxt.data = cx.result;          // [R2]
          s_nxt.cnt  = 4'h1;
          s_nxt.oe   = ~cx.result[HI_MSB - 4'h1]; // [R18]
          s_nxt.st   = L_TX;
        end
        L_TX:
        begin
          s_nxt.cnt = done;
          if (done == BYTE_BITS)
          begin
            s_nxt.oe = 1'b0;               // [R8]
            s_nxt.st = L_MACK;
          end
          else
            s_nxt.oe = ~s_r.data[bsel];    // [R18]
          if (s_r.lower && done == ADDR_BITS)
            s_nxt.track = 1'b1;            // [R20]
        end
        L_MACK:
        begin
          s_nxt.track = 1'b0;
          if (!cx.bit_r && !s_r.lower)
          begin
            s_nxt.lower = 1'b1;            // [R18]
            s_nxt.cnt   = '0;
            s_nxt.oe    = ~s_r.data[LO_MSB];
            s_nxt.st    = L_TX;
          end
          else if (!cx.bit_r)
          begin
            s_nxt.req_tgl = ~s_r.req_tgl;  // [R19]
            s_nxt.lower   = 1'b0;
            s_nxt.st      = L_CONV;
          end
          else
          begin
            s_nxt.st = L_SKIP;             // [R19]
            if (!s_r.rw)
              s_nxt.down_tgl = ~s_r.down_tgl; // [R22] [R12]
          end
        end
        default:
        begin
          s_nxt.oe    = 1'b0;              // [R24]
          s_nxt.track = 1'b0;
        end
      endcase
    end
  end

  // Link state register on the falling serial clock
  always_ff @(negedge scl_in or negedge rst_b)
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;

  assign cx.req_tgl  = s_r.req_tgl;
  assign cx.wake_tgl = s_r.wake_tgl;
  assign cx.down_tgl = s_r.down_tgl;
  assign cx.hs_tgl   = s_r.hs_tgl;

  // Pads are open drain: the outputs only ever pull low
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe     = cx.hold;             // [R1]
  assign sda_oe     = s_r.oe | (s_r.st == L_CONV & ~cx.result[HI_MSB]); // [R18]
  assign track_en   = s_r.track;
  assign adc_power  = cx.hold;             // [R21]
  assign ref_enable = cx.ref_on;
  assign timing_hs  = cx.hs;               // [R14]
  assign sar_code   = cx.code;

  // Checks on the link side
  default clocking lk @(negedge scl_in);
  endclocking
  default disable iff (!rst_b);

  a_ack_on_match: assert property ( // [R13]
    (!st_ev && !sp_ev && s_r.st == L_ADDR && s_r.cnt == BYTE_BITS - 4'h1
     && addr_hit(byte_in[7:1], s_r.adr_s2)) |=> (s_r.st == L_ACK && s_r.oe))
    else $error("matching address not acknowledged");
  a_ack_one_clock: assert property ( // [R8]
    (s_r.st == L_ACK && !st_ev && !sp_ev) |=> !s_r.oe && s_r.st == L_CONV
     && s_r.req_tgl != $past(s_r.req_tgl) && s_r.wake_tgl != $past(s_r.wake_tgl))
    else $error("address acknowledge did not end with conversion request");
  a_miss_no_drive: assert property ( // [R24]
    (!st_ev && !sp_ev && s_r.st == L_ADDR && s_r.cnt == BYTE_BITS - 4'h1
     && !addr_hit(byte_in[7:1], s_r.adr_s2)) |=> !sda_oe ##1 !sda_oe)
    else $error("data driven for a foreign address");
  a_hs_nack_switch: assert property ( // [R15]
    (s_r.st == L_HSNACK && !st_ev && !sp_ev) |-> !sda_oe ##1 (s_r.hs_tgl != $past(s_r.hs_tgl)))
    else $error("master code not answered by release and mode switch");
  a_track_two_clk: assert property ( // [R20]
    ($rose(s_r.track) ##1 (s_r.st == L_ACK || s_r.st == L_MACK)) |=> !s_r.track)
    else $error("input tracked for other than two clocks");
  a_msb_first: assert property ( // [R18]
    (s_r.st == L_CONV && !st_ev && !sp_ev) |-> sda_oe == !cx.result[HI_MSB]
     ##1 s_r.oe == !s_r.data[HI_MSB - 4'h1])
    else $error("result not sent most significant bit first");
  a_stop_frees: assert property ( // [R7]
    (sp_ev && !st_ev) |=> (s_r.st == L_IDLE && !sda_oe))
    else $error("stop did not free the bus");
  a_ref_down_nack: assert property ( // [R22]
    (s_r.st == L_MACK && cx.bit_r && !s_r.rw && !st_ev && !sp_ev)
     |=> s_r.down_tgl != $past(s_r.down_tgl) && s_r.st == L_SKIP)
    else $error("reference shutdown not requested on not-acknowledge");
  a_byte_nine: assert property ( // [R3]
    (s_r.st == L_TX && s_r.cnt == BYTE_BITS - 4'h1 && !st_ev && !sp_ev) |=> s_r.st == L_MACK && !s_r.oe)
    else $error("acknowledge slot not on the ninth clock");

  c_addr_ack: cover property (s_r.st == L_ACK);
  c_hs_switch: cover property (s_r.st == L_HSNACK);
  c_lower_byte: cover property (s_r.st == L_TX && s_r.lower);
  c_continuous: cover property (s_r.st == L_MACK && !cx.bit_r && s_r.lower);
endmodule // atw_top
`default_nettype wire

// ### dv/atw_master.sv
// Bus master model: drives the serial clock and data wires open-drain style.
// Assumes the bench resolves both wires with pull-ups.
`default_nettype none
module atw_master (
  output logic      scl_low,
  output logic      sda_low,
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      tmo
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 32; // Half of the 64 ns link clock period
  time fell;
  int  lowt;
  // Both wires released at start, so the bus idles high
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    tmo     = 1'b0;
    fell    = 0;
    lowt    = 0;
  end
  // Release the clock, then wait while a slave may still stretch it
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl_w !== 1'b1 && n < 20000)
    begin
      #1;
      n++;
    end
    if (n >= 20000)
      tmo = 1'b1;
    lowt = int'($time - fell);
  endtask
  // Pull the clock low and note when
  task automatic fall();
    scl_low = 1'b1;
    fell    = $time;
  endtask
  // One bit per clock; data moves only in the low phase
  task automatic bit_io(input logic b, input int lo, output logic r);
    #(lo / 2) sda_low = ~b;
    #(lo / 2) rise();
    r = sda_w;
    #H fall();
  endtask
  // Eight data clocks and the acknowledge clock; first low phase long
  task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                         output logic ack_rx, output int stretch);
    bit_io(tx[7], 256, rx[7]);
    stretch = lowt;
    for (int i = 6; i >= 0; i--)
      bit_io(tx[i], H, rx[i]);
    bit_io(ack_tx, H, ack_rx);
  endtask
  // Start or repeated start: data falls with the clock high
  task automatic start();
    if (scl_low)
    begin
      #H sda_low = 1'b0;
      #H rise();
    end
    #(2 * H) sda_low = 1'b1;
    #(2 * H) fall();
  endtask
  // Stop: data rises with the clock high, then both lines rest high
  task automatic stop();
    #H sda_low = 1'b1;
    #H rise();
    #(2 * H) sda_low = 1'b0;
    #(2 * H);
  endtask
endmodule // atw_master
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench: master model on the wires, ideal comparator, result queue.
// Assumes the design and the master model are compiled before it.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst_b;
  logic        cmp_in;
  logic        reference_adjust_pin;
  logic [3:0]  address_select_pins;
  logic [15:0] vin;
  logic [15:0] sar_code;
  logic        scl_low;
  logic        sda_low;
  logic        tmo;
  logic        scl_out;
  logic        scl_oe;
  logic        sda_out;
  logic        sda_oe;
  logic        adc_power;
  logic        track_en;
  logic        ref_enable;
  logic        timing_hs;
  logic        sda_seen;
  logic [7:0]  rx;
  logic        a;
  int          st;
  int          fails;
  int          checked;
  int          exp_q[$];
  wire logic   scl_w;
  wire logic   sda_w;
  // Open-drain wires with pull-ups
  assign scl_w = (scl_oe ? scl_out : 1'b1) & ~scl_low;
  assign sda_w = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  atw_top atw_top_i (.clk(clk), .rst_b(rst_b), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pins(address_select_pins),
    .reference_adjust_pin(reference_adjust_pin), .cmp_in(cmp_in), .sar_code(sar_code),
    .adc_power(adc_power), .track_en(track_en), .ref_enable(ref_enable), .timing_hs(timing_hs));
  atw_master atw_master_i (.scl_low(scl_low), .sda_low(sda_low), .scl_w(scl_w), .sda_w(sda_w), .tmo(tmo));
  // 20 MHz system clock
  always #25 clk = ~clk;
  // Ideal comparator against the sampled input level
  always @(posedge clk)
    cmp_in <= (sar_code <= vin);
  // Notes any drive of the data line
  always @(posedge clk)
    if (sda_oe)
      sda_seen <= 1'b1;
  // A hung wire ends the run
  always @(posedge tmo)
  begin
    $display("MISMATCH %0t serial clock stretched past the wait limit", $time);
    fails++;
    report_and_stop();
  end
  task automatic report_and_stop();
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Address a device, read n results (last not acknowledged), then stop
  task automatic read_conv(input logic [7:0] ab, input logic mine, input int n, input logic hs);
    logic [7:0] hi;
    logic [7:0] lo;
    sda_seen = 1'b0;
    atw_master_i.start();
    atw_master_i.byte_io(ab, 1'b1, hi, a, st);
    chk(16'(a), 16'(!mine), "address ack");
    for (int k = 0; k < n; k++)
    begin
      vin = 16'($urandom);
      exp_q.push_back(int'(vin));
      repeat (4) @(posedge clk);
      chk(16'(adc_power), 16'h1, "converter powered");
      atw_master_i.byte_io(8'hFF, 1'b0, hi, a, st);
      chk(16'(st >= 4000 && st <= 4300), 16'h1, "stretch");
      atw_master_i.byte_io(8'hFF, k == n - 1, lo, a, st);
      chk({hi, lo}, 16'(exp_q.pop_front()), "result");
      chk(16'(timing_hs), 16'(hs), "timing mode");
    end
    atw_master_i.stop();
    if (!mine)
      chk(16'(atw_master_i.lowt < 200), 16'h1, "no stretch");
    repeat (4) @(posedge clk);
    chk(16'(sda_seen), 16'(mine), "data drive");
    chk(16'(track_en), 16'h0, "hold");
    chk(16'(adc_power), 16'h0, "power down");
  endtask
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    cmp_in = 1'b0;
    reference_adjust_pin = 1'b0;
    address_select_pins = 4'h0;
    vin = 16'h0;
    sda_seen = 1'b0;
    fails = 0;
    checked = 0;
    void'($urandom(88));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    address_select_pins <= 4'($urandom);
    repeat (3) @(posedge clk);
    chk(16'({scl_w, sda_w}), 16'h3, "idle lines");
    chk(16'({ref_enable, timing_hs}), 16'h0, "power-up state");
    read_conv({3'h3, address_select_pins, 1'b1}, 1'b1, 3, 1'b0);
    chk(16'(ref_enable), 16'h1, "reference woken");
    read_conv({3'h3, address_select_pins ^ (4'h1 << ($urandom % 4)), 1'b1}, 1'b0, 0, 1'b0);
    read_conv({3'h2, address_select_pins, 1'b1}, 1'b0, 0, 1'b0);
    read_conv({3'h3, address_select_pins, 1'b0}, 1'b1, 1, 1'b0);
    chk(16'(ref_enable), 16'h0, "reference shut");
    read_conv({3'h3, address_select_pins, 1'b1}, 1'b1, 1, 1'b0);
    chk(16'(ref_enable), 16'h1, "reference woken");
    @(posedge clk);
    reference_adjust_pin <= 1'b1;
    repeat (4) @(posedge clk);
    read_conv({3'h3, address_select_pins, 1'b1}, 1'b1, 1, 1'b0);
    chk(16'(ref_enable), 16'h0, "external reference");
    reference_adjust_pin <= 1'b0;
    address_select_pins <= 4'($urandom);
    repeat (4) @(posedge clk);
    atw_master_i.start();
    atw_master_i.byte_io({5'h01, 3'($urandom)}, 1'b1, rx, a, st);
    chk(16'(a), 16'h1, "master code refused");
    repeat (4) @(posedge clk);
    chk(16'(timing_hs), 16'h1, "high-speed timing on");
    read_conv({3'h3, address_select_pins, 1'b1}, 1'b1, 2, 1'b1);
    chk(16'(timing_hs), 16'h0, "stop restores timing");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
